/* rtl/nfc_pkg.sv */
// Summary of operation
// RULE1 - every value held internally is an 80-bit extended-precision real
// RULE2 - loads convert 16/32/64-bit integers, single/double reals and 18-digit decimal
// RULE3 - stores convert the internal value to the requested memory format
// RULE4 - operands are little-endian, least significant byte at the lowest address
// RULE5 - host should align operands on four-byte boundaries; misalignment only costs cycles
// RULE6 - the sign is one bit in every signed format, 1 meaning negative
// RULE7 - decimal pad bits are ignored on load and written as zeros on store; an out-of-range store writes NFC_BCD_INDEF with them set
// RULE8 - integer bit explicit in extended, implied in single and double
// RULE9 - exponent biases are 127, 1023 and 16383 for single, double, extended
// RULE10 - packed decimal holds 18 digits, two per byte, signed magnitude
// RULE11 - seven memory formats: three integers, decimal, three binary reals
// RULE12 - host does all memory access; behaviour independent of host mode
// RULE13 - next command is accepted while the current one still executes
// RULE14 - one memory operand per command and one result
// RULE15 - stores always take the value at the top of the register stack
package nfc_pkg;
   // ----------------------------------------------------------------------
   // formats and phases
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {NFC_W16, NFC_I32, NFC_I64, NFC_BCD, NFC_SGL, NFC_DBL, NFC_EXT} nfc_fmt_t;
   typedef enum logic [2:0] {PH_IDLE, PH_BCD_IN, PH_NORM, PH_SHR, PH_BCD_DD} nfc_ph_t;
   // ----------------------------------------------------------------------
   // field layout and constants
   // ----------------------------------------------------------------------
   localparam logic [14:0] NFC_BIAS_X = 15'h3FFF;
   localparam logic [14:0] NFC_BIAS_S = 15'h007F;
   localparam logic [14:0] NFC_BIAS_D = 15'h03FF;
   localparam logic [14:0] NFC_EMAX_S = 15'h00FF;
   localparam logic [14:0] NFC_EMAX_D = 15'h07FF;
   localparam logic [14:0] NFC_EXP_TOP = 15'h7FFF;
   localparam logic [14:0] NFC_INT_EXP = 15'h403E; // bias plus 63: binary point below bit 0
   localparam int NFC_SIGN_POS = 79;
   localparam logic [6:0] NFC_BCD_DIGITS = 7'h12;
   localparam logic [6:0] NFC_INT_BITS = 7'h40;
   localparam logic [63:0] NFC_BCD_LIMIT = 64'h0DE0_B6B3_A764_0000; // ten to the eighteenth
   localparam logic [79:0] NFC_BCD_INDEF = 80'hFFFF_C000_0000_0000_0000;
   localparam logic [79:0] NFC_RESET_VAL = 80'h0000_0000_0000_0000_0000;
endpackage : nfc_pkg

/* rtl/nfc_converter.sv */
`timescale 1ns/1ps
module nfc_converter #(
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // command from host
   input wire logic cmd_valid,
   input wire logic cmd_store,
   input wire nfc_pkg::nfc_fmt_t cmd_fmt,
   input wire logic [79:0] cmd_data,
   output logic cmd_ready,
   // result to host
   output logic done,
   output logic res_valid,
   output logic [79:0] res_data,
   output logic busy
);
   import nfc_pkg::*;
   localparam int TW = $clog2(DEPTH);

   typedef struct packed {
      nfc_ph_t ph;
      logic pend_v;
      logic pend_st;
      nfc_fmt_t pend_fmt;
      logic [79:0] pend_data;
      nfc_fmt_t fmt;
      logic sign;
      logic ovf;
      logic [14:0] exp;
      logic [63:0] mant;
      logic [71:0] bcd;
      logic [6:0] cnt;
      logic [TW-1:0] top;
      logic [DEPTH-1:0][79:0] stk;
      logic cmd_ready;
      logic done;
      logic res_valid;
      logic [79:0] res;
      logic busy;
   } nfc_state_t;

   nfc_state_t q, d;
   logic push;
   logic [79:0] push_val;

   // ----------------------------------------------------------------------
   // conversion helpers
   // ----------------------------------------------------------------------
   function automatic logic [6:0] int_width(input nfc_fmt_t f);
      return (f == NFC_W16) ? 7'h10 : (f == NFC_I32) ? 7'h20 : NFC_INT_BITS;
   endfunction : int_width

   // sign extend the integer image; byte 0 holds the lowest address
   function automatic logic [63:0] int_sext(input logic [79:0] v, input nfc_fmt_t f);
      unique case (f)
         NFC_W16: return {{48{v[15]}}, v[15:0]};
         NFC_I32: return {{32{v[31]}}, v[31:0]};
         default: return v[63:0];
      endcase
   endfunction : int_sext

   // single or double image to extended form
   function automatic logic [79:0] from_real(input logic [79:0] v, input logic dbl);
      logic s;
      logic [14:0] e;
      logic [62:0] f;
      s = dbl ? v[63] : v[31];
      e = dbl ? {4'h0, v[62:52]} : {7'h00, v[30:23]};
      f = dbl ? {v[51:0], 11'h000} : {v[22:0], 40'h00_0000_0000};
      if (e == 15'h0000) begin
         return {s, 79'h0}; // denormals flushed to signed zero
      end else if (e == (dbl ? NFC_EMAX_D : NFC_EMAX_S)) begin
         return {s, NFC_EXP_TOP, 1'b1, f};
      end else begin
         return {s, 15'(e - (dbl ? NFC_BIAS_D : NFC_BIAS_S) + NFC_BIAS_X), 1'b1, f}; // RULE9 RULE8
      end
   endfunction : from_real

   // extended form to single or double image, truncating the fraction
   function automatic logic [79:0] to_real(input logic [79:0] t, input logic dbl);
      logic s;
      logic [16:0] ue;
      logic [16:0] emax;
      logic [62:0] f;
      s = t[79];
      f = t[62:0];
      ue = {2'b00, t[78:64]} - {2'b00, NFC_BIAS_X} + {2'b00, dbl ? NFC_BIAS_D : NFC_BIAS_S}; // RULE9
      emax = {2'b00, dbl ? NFC_EMAX_D : NFC_EMAX_S};
      if (t[78:64] == NFC_EXP_TOP || (!ue[16] && ue >= emax)) begin
         if (t[78:64] != NFC_EXP_TOP) begin
            f = 63'h0;
         end
         ue = emax;
      end else if (!t[63] || ue[16] || ue == 17'h0_0000) begin
         ue = 17'h0_0000;
         f = 63'h0;
      end
      // integer bit dropped from the image
      if (dbl) begin
         return {16'h0000, s, ue[10:0], f[62:11]}; // RULE8 RULE6
      end else begin
         return {48'h0000_0000_0000, s, ue[7:0], f[62:40]}; // RULE8 RULE6
      end
   endfunction : to_real

   // add three to every decimal digit of five or more
   function automatic logic [71:0] dd_adjust(input logic [71:0] b);
      logic [71:0] r;
      r = b;
      for (int i = 0; i < 18; i++) begin
         if (r[4*i +: 4] >= 4'h5) begin
            r[4*i +: 4] = r[4*i +: 4] + 4'h3;
         end
      end
      return r;
   endfunction : dd_adjust

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [79:0] t;
      logic [63:0] iv;
      logic [63:0] lim;
      logic [71:0] b;
      t = q.stk[q.top];
      iv = 64'h0;
      lim = 64'h0;
      b = 72'h0;
      d = q;
      d.done = 1'b0;
      d.res_valid = 1'b0;
      push = 1'b0;
      push_val = NFC_RESET_VAL;
      // holding slot takes the next command during execution
      if (cmd_valid && q.cmd_ready) begin // RULE13
         d.pend_v = 1'b1;
         d.pend_st = cmd_store;
         d.pend_fmt = cmd_fmt;
         d.pend_data = cmd_data; // RULE4 RULE12
      end
      unique case (q.ph)
         PH_IDLE: begin
            if (q.pend_v) begin
               d.pend_v = 1'b0;
               d.fmt = q.pend_fmt;
               d.ovf = 1'b0;
               if (!q.pend_st) begin
                  unique case (q.pend_fmt) // RULE2 RULE11
                     NFC_W16, NFC_I32, NFC_I64: begin
                        iv = int_sext(q.pend_data, q.pend_fmt);
                        d.sign = iv[63]; // RULE6
                        d.mant = iv[63] ? 64'(-iv) : iv;
                        d.exp = NFC_INT_EXP;
                        d.ph = PH_NORM;
                     end
                     NFC_BCD: begin
                        d.sign = q.pend_data[NFC_SIGN_POS];
                        d.bcd = q.pend_data[71:0]; // RULE7
                        d.mant = 64'h0;
                        d.exp = NFC_INT_EXP;
                        d.cnt = NFC_BCD_DIGITS;
                        d.ph = PH_BCD_IN;
                     end
                     NFC_SGL, NFC_DBL: begin
                        push = 1'b1;
                        push_val = from_real(q.pend_data, q.pend_fmt == NFC_DBL);
                     end
                     default: begin
                        push = 1'b1;
                        push_val = q.pend_data;
                     end
                  endcase
               end else begin
                  // stores pop the top of the stack
                  d.top = TW'(q.top + 1'b1); // RULE15
                  d.sign = t[79];
                  d.mant = t[63:0];
                  d.exp = t[78:64];
                  unique case (q.pend_fmt) // RULE3
                     NFC_SGL, NFC_DBL: begin
                        d.res = to_real(t, q.pend_fmt == NFC_DBL);
                        d.done = 1'b1;
                        d.res_valid = 1'b1;
                     end
                     NFC_EXT: begin
                        d.res = t;
                        d.done = 1'b1;
                        d.res_valid = 1'b1;
                     end
                     default: begin
                        if (t[78:64] < NFC_BIAS_X) begin
                           d.mant = 64'h0; // fractions truncate to zero
                           d.exp = NFC_INT_EXP;
                        end else if (t[78:64] > NFC_INT_EXP) begin
                           d.ovf = 1'b1;
                           d.exp = NFC_INT_EXP;
                        end
                        d.ph = PH_SHR;
                     end
                  endcase
               end
            end
         end
         PH_BCD_IN: begin
            // accumulate digit 17 down to digit 0
            d.mant = (q.mant << 3) + (q.mant << 1) + {60'h0, q.bcd[71:68]}; // RULE10
            d.bcd = q.bcd << 4;
            d.cnt = q.cnt - 7'h01;
            if (q.cnt == 7'h01) begin
               d.ph = PH_NORM;
            end
         end
         PH_NORM: begin
            if (q.mant == 64'h0) begin
               push = 1'b1;
               push_val = {q.sign, 79'h0};
               d.ph = PH_IDLE;
            end else if (q.mant[63]) begin
               push = 1'b1;
               push_val = {q.sign, q.exp, q.mant}; // RULE1 RULE8
               d.ph = PH_IDLE;
            end else begin
               d.mant = q.mant << 1;
               d.exp = q.exp - 15'h0001;
            end
         end
         PH_SHR: begin
            if (q.exp != NFC_INT_EXP) begin
               d.mant = q.mant >> 1;
               d.exp = q.exp + 15'h0001;
            end else if (q.fmt == NFC_BCD) begin
               if (q.ovf || q.mant >= NFC_BCD_LIMIT) begin
                  d.res = NFC_BCD_INDEF;
                  d.done = 1'b1;
                  d.res_valid = 1'b1;
                  d.ph = PH_IDLE;
               end else begin
                  d.bcd = 72'h0;
                  d.cnt = NFC_INT_BITS;
                  d.ph = PH_BCD_DD;
               end
            end else begin
               lim = 64'h1 << (int_width(q.fmt) - 7'h01);
               iv = q.sign ? 64'(-q.mant) : q.mant;
               if (q.ovf || q.mant > lim || (q.mant == lim && !q.sign)) begin
                  iv = lim; // out of range gives most negative value
               end
               d.res = {16'h0000, iv & ((int_width(q.fmt) == NFC_INT_BITS) ? 64'hFFFF_FFFF_FFFF_FFFF
                                                                           : (lim << 1) - 64'h1)}; // RULE4
               d.done = 1'b1;
               d.res_valid = 1'b1;
               d.ph = PH_IDLE;
            end
         end
         PH_BCD_DD: begin
            b = dd_adjust(q.bcd);
            d.bcd = {b[70:0], q.mant[63]};
            d.mant = q.mant << 1;
            d.cnt = q.cnt - 7'h01;
            if (q.cnt == 7'h01) begin
               d.res = {q.sign, 7'h00, b[70:0], q.mant[63]}; // RULE7 RULE10
               d.done = 1'b1;
               d.res_valid = 1'b1;
               d.ph = PH_IDLE;
            end
         end
      endcase
      // a load leaves one new value on the stack
      if (push) begin // RULE14
         d.top = TW'(q.top - 1'b1);
         d.stk[TW'(q.top - 1'b1)] = push_val;
         d.done = 1'b1;
      end
      d.cmd_ready = !d.pend_v;
      d.busy = (d.ph != PH_IDLE) || d.pend_v;
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.cmd_ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign cmd_ready = q.cmd_ready;
   assign done = q.done;
   assign res_valid = q.res_valid;
   assign res_data = q.res;
   assign busy = q.busy;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence s_bcd_run;
      (q.ph == PH_BCD_IN) [*8] ##1 (q.ph == PH_BCD_IN) [*8] ##1 (q.ph == PH_BCD_IN) [*2];
   endsequence
   sequence s_bcd_exit;
      (q.ph == PH_NORM);
   endsequence

   a_slot_ready: assert property (@(posedge clk) disable iff (!arst_n) // RULE13
      cmd_valid && cmd_ready |=> !cmd_ready ##0 busy) else $error("holding slot not taken");
   a_ext_explicit: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
      push && push_val[78:64] != 15'h0000 |-> push_val[63]) else $error("integer bit missing");
   a_bcd_pad: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
      res_valid && q.fmt == NFC_BCD && res_data != NFC_BCD_INDEF |-> res_data[78:72] == 7'h00)
      else $error("decimal pad bits not zero");
   a_real_sign: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
      res_valid && q.fmt == NFC_SGL |-> res_data[31] == $past(q.stk[q.top][79]))
      else $error("single sign mismatch");
   a_bcd_digits: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
      $rose(q.ph == PH_BCD_IN) |-> s_bcd_run ##1 s_bcd_exit) else $error("digit count wrong");
   a_norm_bound: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
      q.ph == PH_NORM |-> ##[1:64] q.ph == PH_IDLE) else $error("normalise too long");
   a_store_pop: assert property (@(posedge clk) disable iff (!arst_n) // RULE15
      q.ph == PH_IDLE && q.pend_v && q.pend_st |=> q.top == TW'($past(q.top) + 1'b1))
      else $error("store did not pop");
   a_load_push: assert property (@(posedge clk) disable iff (!arst_n) // RULE14
      push |=> done && q.stk[q.top] == $past(push_val)) else $error("load value not on top");
   a_dd_bound: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
      $rose(q.ph == PH_BCD_DD) |-> ##64 res_valid) else $error("decimal store length wrong");
endmodule : nfc_converter

/* verif/nfc_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// host side: hands whole operand images to the converter
// ----------------------------------------------------------------------
module nfc_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // command to converter
   output logic cmd_valid,
   output logic cmd_store,
   output nfc_pkg::nfc_fmt_t cmd_fmt,
   output logic [79:0] cmd_data,
   input wire logic cmd_ready
);
   import nfc_pkg::*;

   // quiet at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_store = 1'b0;
      cmd_fmt = NFC_W16;
      cmd_data = 80'h5A5A_5A5A_5A5A_5A5A_5A5A;
   end

   // offer one command after an edge, hold it until taken
   task automatic send(input logic st, input nfc_fmt_t f, input logic [79:0] d);
      cmd_valid <= 1'b1;
      cmd_store <= st;
      cmd_fmt <= f;
      cmd_data <= d;
      do @(posedge clk); while (cmd_ready !== 1'b1);
   endtask : send

   // release the request; data lines are inverted once so stale values never match
   task automatic idle();
      cmd_valid <= 1'b0;
      cmd_data <= ~cmd_data;
   endtask : idle
endmodule : nfc_host_model

/* verif/numeric_format_converter_test.sv */
`timescale 1ns/1ps
`define NFC_CHECK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("MISMATCH %s expected %h seen %h", what, exp, got); \
      end \
   end
// ----------------------------------------------------------------------
// self-checking bench for the format converter
// ----------------------------------------------------------------------
module numeric_format_converter_test;
   import nfc_pkg::*;
   logic clk;
   logic arst_n;
   logic cmd_valid;
   logic cmd_store;
   nfc_fmt_t cmd_fmt;
   logic [79:0] cmd_data;
   logic cmd_ready;
   logic done;
   logic res_valid;
   logic [79:0] res_data;
   logic busy;
   int seed = 29552;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic exp_store_q[$];
   logic [79:0] exp_data_q[$];
   logic [79:0] d;

   nfc_converter #(.DEPTH(8)) nfc_converter_inst (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
      .cmd_store(cmd_store), .cmd_fmt(cmd_fmt), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done),
      .res_valid(res_valid), .res_data(res_data), .busy(busy));
   nfc_host_model nfc_host_model_inst (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
      .cmd_store(cmd_store), .cmd_fmt(cmd_fmt), .cmd_data(cmd_data), .cmd_ready(cmd_ready));

   // clock, 100 ns period
   initial clk = 1'b0;
   always #50 clk = ~clk;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // print counts and verdict, end the run
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   // note the expected result, then hand the command to the host
   task automatic cmd(input logic st, input nfc_fmt_t f, input logic [79:0] dat, input logic [79:0] e);
      exp_store_q.push_back(st);
      exp_data_q.push_back(e);
      nfc_host_model_inst.send(st, f, dat);
   endtask : cmd

   // release the host and wait until every note is used
   task automatic drain(input string name);
      nfc_host_model_inst.idle();
      while (exp_store_q.size() != 0) @(posedge clk);
      `NFC_CHECK("busy", 1'b0, busy)
      `NFC_CHECK("cmd_ready", 1'b1, cmd_ready)
      $display("test %s finished", name);
   endtask : drain

   // legal random memory image of a format, junk in unused bytes
   function automatic logic [79:0] rand_image(input nfc_fmt_t f);
      logic [79:0] r;
      r = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      case (f)
         NFC_SGL: r[30:23] = 8'h01 + 8'({$random(seed)} % 32'h0000_00FE);
         NFC_DBL: r[62:52] = 11'h001 + 11'({$random(seed)} % 32'h0000_07FE);
         NFC_EXT: r[79:63] = {r[79], 15'h0001 + 15'({$random(seed)} % 32'h0000_7FFE), 1'b1};
         NFC_BCD: for (int k = 0; k < 18; k++) r[4*k +: 4] = 4'({$random(seed)} % 32'h0000_000A);
         default: r = r;
      endcase
      return r;
   endfunction : rand_image

   // store image expected back: unused bytes and pad bits zero
   function automatic logic [79:0] keep(input nfc_fmt_t f, input logic [79:0] v);
      case (f)
         NFC_W16: return {64'h0, v[15:0]};
         NFC_I32, NFC_SGL: return {48'h0, v[31:0]};
         NFC_I64, NFC_DBL: return {16'h0, v[63:0]};
         NFC_BCD: return {v[79], 7'h00, v[71:0]};
         default: return v;
      endcase
   endfunction : keep

   // ----------------------------------------------------------------------
   // watchers
   // ----------------------------------------------------------------------
   // take the oldest note whenever a command completes
   always @(posedge clk) begin
      if (arst_n === 1'b1 && done === 1'b1) begin
         if (exp_store_q.size() == 0) begin
            fail_count++;
            $display("MISMATCH done expected 0 seen 1");
         end else begin
            `NFC_CHECK("res_valid", exp_store_q[0], res_valid)
            if (exp_store_q[0] === 1'b1) `NFC_CHECK("res_data", exp_data_q[0], res_data)
            void'(exp_store_q.pop_front());
            void'(exp_data_q.pop_front());
         end
      end else if (arst_n === 1'b1 && res_valid === 1'b1) begin
         `NFC_CHECK("res_valid alone", 1'b0, res_valid)
      end
   end

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("MISMATCH timeout expected 0 seen 1");
         test_done();
      end
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      repeat (19) @(posedge clk);
      `NFC_CHECK("reset state", 4'b1000, {cmd_ready, done, res_valid, busy})
      `NFC_CHECK("reset res_data", 80'h0, res_data)
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      // every format loaded and stored back, commands back to back
      for (int i = 0; i < 4; i++) begin
         for (int f = 0; f < 7; f++) begin
            d = rand_image(nfc_fmt_t'(f));
            cmd(1'b0, nfc_fmt_t'(f), d, 80'h0);
            cmd(1'b1, nfc_fmt_t'(f), ~d, keep(nfc_fmt_t'(f), d));
         end
      end
      drain("round trip");
      // loads in one format, stores in another
      cmd(1'b0, NFC_W16, 80'hDEAD_BEEF_0000_0000_0001, 80'h0);
      cmd(1'b1, NFC_EXT, 80'h0, 80'h3FFF_8000_0000_0000_0000);
      cmd(1'b0, NFC_W16, 80'h0000_0000_0000_0000_FFFF, 80'h0);
      cmd(1'b1, NFC_SGL, 80'h0, 80'h0000_0000_0000_BF80_0000);
      cmd(1'b0, NFC_SGL, 80'h1234_0000_0000_3F80_0000, 80'h0);
      cmd(1'b1, NFC_DBL, 80'h0, 80'h0000_3FF0_0000_0000_0000);
      cmd(1'b0, NFC_BCD, 80'hFF00_0000_0000_0000_0012, 80'h0);
      cmd(1'b1, NFC_W16, 80'h0, 80'h0000_0000_0000_0000_FFF4);
      cmd(1'b0, NFC_I32, 80'h0000_0000_0000_FFFF_FFFB, 80'h0);
      cmd(1'b1, NFC_BCD, 80'h0, 80'h8000_0000_0000_0000_0005);
      cmd(1'b0, NFC_I64, 80'h0000_8000_0000_0000_0000, 80'h0);
      cmd(1'b1, NFC_DBL, 80'h0, 80'h0000_C3E0_0000_0000_0000);
      cmd(1'b0, NFC_DBL, 80'h0000_4000_0000_0000_0000, 80'h0);
      cmd(1'b1, NFC_I32, 80'h0, 80'h0000_0000_0000_0000_0002);
      drain("cross format");
      // overflow to most negative value, decimal out of range, infinity, underflow and a flushed denormal
      cmd(1'b0, NFC_I32, 80'h0000_0000_0000_0001_0000, 80'h0);
      cmd(1'b1, NFC_W16, 80'h0, 80'h0000_0000_0000_0000_8000);
      cmd(1'b0, NFC_I64, 80'h0000_7FFF_FFFF_FFFF_FFFF, 80'h0);
      cmd(1'b1, NFC_BCD, 80'h0, NFC_BCD_INDEF);
      cmd(1'b0, NFC_EXT, 80'h7FFE_8000_0000_0000_0000, 80'h0);
      cmd(1'b1, NFC_SGL, 80'h0, 80'h0000_0000_0000_7F80_0000);
      cmd(1'b0, NFC_EXT, 80'h8001_8000_0000_0000_0000, 80'h0);
      cmd(1'b1, NFC_DBL, 80'h0, 80'h0000_8000_0000_0000_0000);
      cmd(1'b0, NFC_SGL, 80'h0000_0000_0000_0000_0001, 80'h0);
      cmd(1'b1, NFC_EXT, 80'h0, 80'h0);
      drain("range limits");
      // stores always take the stack top, last loaded first
      for (int k = 1; k <= 3; k++) cmd(1'b0, NFC_W16, 80'(k), 80'h0);
      for (int k = 3; k >= 1; k--) cmd(1'b1, NFC_W16, 80'h0, 80'(k));
      drain("stack order");
      test_done();
   end
endmodule : numeric_format_converter_test
